// [ric_top.sv]
`timescale 1ns/1ps
`include "ric_defines.svh"
// What this block does
// - Four reset sources: pin, fetch trap, watchdog, illegal clock disable.
// - A malfunction reset holds internal reset for at most 24 clock periods.
// - Malfunction reset may fire briefly at power-up; tolerated.
// - Reset clears enables, latches, selector and pending requests; stack and cause kept.
// - Reset leaves watchdog enabled.
// - Pin held low twelve periods resets and initialises internal state.
// - On pin release, fetch reset vector FFFE and start there.
// - Fetch from SFR area, or RAM when area select set, traps.
// - Trap action select picks reset (default) or non-maskable interrupt.
// - Watchdog action select picks reset (default) or non-maskable interrupt.
// - Clock reset on three illegal oscillator-disable writes.
// - Illegal disable write leaves oscillators running.
// - Seventeen sources, one shared level, four non-maskable.
// - Nesting allowed once software re-enables interrupts in a handler.
// - Each source has its vector and, where present, its request latch.
// - Maskable request needs master enable and its own enable.
// - Fixed priority; software and illegal-opcode first, then trap, then watchdog.
// - Software and illegal-opcode interrupts have no latch, share FFFC.
// - Trap uses latch 2 vector FFFA; watchdog latch 3 vector FFF8.
// - Source n uses bit n, vector FFF6-2(n-4); ext0 needs pin enable.
// - Level 11 serves timer four or ext pin 3 by select bit.
// - Source selector register picks the shared level's source.
// - Latch clears when the core accepts its interrupt.
// - Acceptance pushes then clears master enable; return restores it.
// - Writing 0 clears a latch; writing 1 never sets one.
module ric_top
  import ric_pkg::*;
#(
  parameter logic [15:0] SFR_BASE = 16'h0000,
  parameter logic [15:0] SFR_LAST = 16'h003f,
  parameter logic [15:0] RAM_BASE = 16'h0040,
  parameter logic [15:0] RAM_LAST = 16'h013f
) (
  input  wire logic        mclk,               // Main clock
  input  wire logic        reset_n,            // Power-on reset, sync
  input  wire logic        ext_reset_pin_n,    // Reset pin, asynchronous
  input  wire logic [3:0]  reg_addr,           // Register word index
  input  wire logic [15:0] reg_wdata,          // Write data
  input  wire logic        reg_wr,             // Write strobe
  input  wire logic        reg_rd,             // Read strobe
  output logic      [15:0] reg_rdata,          // Read data, next cycle
  input  wire logic        fetch_valid,        // Core opcode fetch
  input  wire logic [15:0] fetch_addr,         // Fetch address
  input  wire logic        wdog_timeout,       // Watchdog expiry pulse
  input  wire logic        software_irq,       // Software interrupt pulse
  input  wire logic        illegal_opcode_irq, // Undefined opcode pulse
  input  wire logic        ext_pin0_irq,       // Level 4 request
  input  wire logic        ext_pin1_irq,       // Level 5 request
  input  wire logic        time_base_irq,      // Level 6 request
  input  wire logic        timer_one_irq,      // Level 7 request
  input  wire logic        serial_rx_irq,      // Level 8 request
  input  wire logic        serial_tx_irq,      // Level 9 request
  input  wire logic        timer_three_irq,    // Level 10 request
  input  wire logic        timer_four_irq,     // Level 11, select 0
  input  wire logic        ext_pin3_irq,       // Level 11, select 1
  input  wire logic        converter_done_irq, // Level 12 request
  input  wire logic        sync_serial_irq,    // Level 13 request
  input  wire logic        ext_pin4_irq,       // Level 14 request
  input  wire logic        ext_pin5_irq,       // Level 15 request
  input  wire logic        irq_ack,            // Core took the vector
  input  wire logic        reti_strobe,        // Return from interrupt
  output logic             core_reset_n,       // Internal reset, low active
  output logic             irq_req,            // Vector waiting for core
  output logic      [15:0] irq_vector,         // Vector address
  output logic             high_osc_enable,    // High oscillator on
  output logic             low_osc_enable,     // Low oscillator on
  output logic             main_clk_sel,       // 1 = low clock is main
  output logic             wdog_enable         // Watchdog run enable
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (SFR_LAST < SFR_BASE || RAM_LAST < RAM_BASE) begin : g_bad_area
    $error("ric_top: trap area bounds reversed");
  end
  // The hold counter is five bits wide and must run at least once
  if (`RIC_MALF_CYCLES < 1 || `RIC_MALF_CYCLES > 31) begin : g_bad_hold
    $error("ric_top: malfunction hold does not fit the counter");
  end

  // ----------------------------------------
  // Constants and helpers
  // ----------------------------------------
  // Hold length in main clock cycles, cut to the counter width
  localparam logic [4:0] MALF_CYC = 5'(`RIC_MALF_CYCLES);
  localparam logic [3:0] WDCTL_RST = 4'hf;
  localparam logic [2:0] SYSCTL_RST = 3'h1;

  // Power-on values; the pin is taken as low until sampled
  localparam ric_state_t RST_S = '{
    pin_s1: 1'b0, pin_s2: 1'b0, malf_cnt: 5'h00, sys_rst_n: 1'b0,
    phase: RIC_PH_RESET, master_irq_enable: 1'b0, ef: 12'h000, il: 14'h0000,
    imf_stk: 16'h0000, wdctl: WDCTL_RST, sysctl: SYSCTL_RST,
    sel: 2'h0, swi_pend: 1'b0, pend: 1'b0, src: 4'h0,
    vec: 16'h0000, cause: 4'h0, rdata: 16'h0000};

  // Address inside an inclusive window
  function automatic logic in_area(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    in_area = (a >= lo) && (a <= hi);
  endfunction

  // Lowest set index wins, so the lower level has priority
  function automatic logic [3:0] first_set(input logic [15:0] m);
    first_set = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction

  // Vector table steps down two bytes per source index
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    vec_of = `RIC_VEC_TOP - {11'h000, idx, 1'b0};
  endfunction

  // Register read mux
  function automatic logic [15:0] rd_word(input ric_state_t s,
                                          input logic [3:0] a);
    rd_word = 16'h0000;
    unique case (a)
      `RIC_OFS_ENABLE: rd_word = {s.ef, 3'h0, s.master_irq_enable};
      `RIC_OFS_LATCH:  rd_word = {s.il, 2'h0};
      `RIC_OFS_WDCTL:  rd_word = {12'h000, s.wdctl};
      `RIC_OFS_SYSCTL: rd_word = {13'h0000, s.sysctl};
      `RIC_OFS_SELECT: rd_word = {14'h0000, s.sel};
      `RIC_OFS_CAUSE:  rd_word = {12'h000, s.cause};
      `RIC_OFS_VECTOR: rd_word = s.vec;
      default:         rd_word = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------
  // State and combinational terms
  // ----------------------------------------
  ric_state_t  s_q;
  ric_state_t  s_d;
  logic        in_reset;
  logic        trap_hit;
  logic        sys_wr;
  logic        clr_hi;
  logic        clr_lo;
  logic        clk_fault;
  logic        trap_rst;
  logic        wdog_rst;
  logic        malf;
  logic [15:2] set_il;
  logic [15:0] nmi_m;
  logic [15:0] mask_m;
  logic        l11_req;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // Read data lasts one cycle, zero otherwise
    s_d.rdata = 16'h0000;

    s_d.pin_s1 = ext_reset_pin_n;
    s_d.pin_s2 = s_q.pin_s1;

    // Any low level that survives two flops resets; no filter
    // pin low or counter running holds reset
    in_reset = ~s_q.pin_s2 | (s_q.malf_cnt != 5'h00);

    // Windows are parameters so a smaller part can shrink them
    // trap on SFR fetch, or RAM when enabled
    trap_hit = fetch_valid &&
               (in_area(fetch_addr, SFR_BASE, SFR_LAST) ||
                (s_q.wdctl[`RIC_WD_RAM_AREA] &&
                 in_area(fetch_addr, RAM_BASE, RAM_LAST)));

    // Only clearing an enable that is set counts as a disable
    // illegal oscillator disable write
    sys_wr = reg_wr && (reg_addr == `RIC_OFS_SYSCTL);
    clr_hi = sys_wr & s_q.sysctl[`RIC_SC_HI_EN] & ~reg_wdata[`RIC_SC_HI_EN];
    clr_lo = sys_wr & s_q.sysctl[`RIC_SC_LO_EN] & ~reg_wdata[`RIC_SC_LO_EN];
    clk_fault = (clr_hi & clr_lo) |
                (clr_hi & ~s_q.sysctl[`RIC_SC_CLK_SEL]) |
                (clr_lo & s_q.sysctl[`RIC_SC_CLK_SEL]);

    // trap reset when its action bit is set
    trap_rst = trap_hit & s_q.wdctl[`RIC_WD_TRAP_ACT];
    // watchdog reset when its action bit is set
    wdog_rst = wdog_timeout & s_q.wdctl[`RIC_WD_WDOG_ACT];
    // Gated by the hold so a cause during reset cannot restart it
    // three malfunction sources
    malf = ~in_reset & (trap_rst | wdog_rst | clk_fault);

    // hold counter, loaded once, counts to zero
    if (malf) begin
      s_d.malf_cnt = MALF_CYC;
    end else if (s_q.malf_cnt != 5'h00) begin
      s_d.malf_cnt = s_q.malf_cnt - 5'h01;
    end

    // Survives internal reset so software can tell why it restarted
    // Reset cause: write 1 clears, a new cause wins
    if (reg_wr && reg_addr == `RIC_OFS_CAUSE) begin
      s_d.cause = s_q.cause & ~reg_wdata[3:0];
    end
    s_d.cause = s_d.cause |
                {clk_fault & malf, wdog_rst & malf, trap_rst & malf, ~s_q.pin_s2};

    // Registered so the core never sees a decode glitch
    // one registered internal reset
    s_d.sys_rst_n = ~in_reset;

    // A select change does not move a request already latched
    // Level 11 source chosen by the selector
    // shared level
    l11_req = s_q.sel[`RIC_SEL_L11] ? ext_pin3_irq : timer_four_irq;

    // trap and watchdog interrupts on latches 2 and 3
    set_il = {ext_pin5_irq, ext_pin4_irq, sync_serial_irq,
              converter_done_irq, l11_req, timer_three_irq,
              serial_tx_irq, serial_rx_irq, timer_one_irq,
              time_base_irq, ext_pin1_irq, ext_pin0_irq,
              wdog_timeout & ~s_q.wdctl[`RIC_WD_WDOG_ACT],
              trap_hit & ~s_q.wdctl[`RIC_WD_TRAP_ACT]};

    // non-maskable candidates, trap latch ahead of watchdog latch
    nmi_m = {12'h000, s_q.il[3:2], 2'h0};
    // maskable needs master and own enable
    // ext0 also needs its pin enable
    mask_m = {s_q.il[15:5] & s_q.ef[15:5],
              s_q.il[4] & s_q.ef[4] & s_q.sel[`RIC_SEL_EXT0],
              4'h0} & {16{s_q.master_irq_enable}};

    // Requests seen during the hold are dropped
    if (in_reset) begin
      // enables and latches cleared, stack kept
      s_d.master_irq_enable = 1'b0;
      s_d.ef = '0;
      s_d.il = '0;
      // watchdog left enabled, clocks back to defaults
      s_d.wdctl = WDCTL_RST;
      s_d.sysctl = SYSCTL_RST;
      s_d.sel = 2'h0;
      s_d.swi_pend = 1'b0;
      s_d.pend = 1'b0;
      s_d.phase = RIC_PH_RESET;
    end else begin
      // Software sees its writes one cycle later
      // Register writes
      if (reg_wr) begin
        unique case (reg_addr)
          `RIC_OFS_ENABLE: begin
            s_d.master_irq_enable = reg_wdata[`RIC_EN_IMF];
            s_d.ef = reg_wdata[15:4];
          end
          `RIC_OFS_LATCH: begin
            s_d.il = s_q.il & reg_wdata[15:2];
          end
          `RIC_OFS_WDCTL: begin
            s_d.wdctl = reg_wdata[3:0];
          end
          `RIC_OFS_SYSCTL: begin
            // an illegal disable write is dropped
            if (!clk_fault) begin
              s_d.sysctl = reg_wdata[2:0];
            end
          end
          `RIC_OFS_SELECT: begin
            s_d.sel = reg_wdata[1:0];
          end
          default: begin
          end
        endcase
      end

      // Return first, so a same-cycle acceptance still pushes
      // return restores the pushed master enable
      if (reti_strobe) begin
        s_d.master_irq_enable = s_q.imf_stk[0];
        s_d.imf_stk = {1'b0, s_q.imf_stk[15:1]};
      end

      // Sixteen nesting levels; a deeper chain loses the oldest enable
      // Core acknowledges the presented vector
      if (irq_ack && s_q.pend) begin
        s_d.pend = 1'b0;
        if (s_q.phase == RIC_PH_BOOT) begin
          s_d.phase = RIC_PH_RUN;
        end else begin
          s_d.imf_stk = {s_q.imf_stk[14:0], s_q.master_irq_enable};
          s_d.master_irq_enable = 1'b0;
          if (s_q.src >= 4'h2) begin
            s_d.il[s_q.src] = 1'b0;
          end
          if (s_q.src == `RIC_SRC_SWI) begin
            s_d.swi_pend = 1'b0;
          end
        end
      end

      // Late software clears must not hide a fresh event
      // New requests win over any clear this cycle
      s_d.il = s_d.il | set_il;
      // no latch, only a hold until accepted
      s_d.swi_pend = s_d.swi_pend | software_irq | illegal_opcode_irq;

      // Boot vector goes out before any source is considered
      // first free cycle presents the reset vector
      if (s_q.phase == RIC_PH_RESET) begin
        s_d.phase = RIC_PH_BOOT;
        s_d.pend = 1'b1;
        s_d.src = `RIC_SRC_BOOT;
        s_d.vec = `RIC_VEC_TOP;
      end else if (s_q.phase == RIC_PH_RUN && !s_q.pend) begin
        // a handler that sets master enable may be preempted
        if (s_q.swi_pend) begin
          s_d.pend = 1'b1;
          s_d.src = `RIC_SRC_SWI;
        end else if (nmi_m != 16'h0000) begin
          s_d.pend = 1'b1;
          s_d.src = first_set(nmi_m);
        end else if (mask_m != 16'h0000) begin
          s_d.pend = 1'b1;
          s_d.src = first_set(mask_m);
        end
        s_d.vec = vec_of(s_d.src);
      end
    end

    // Read data valid in the cycle after the strobe only
    if (reg_rd) begin
      s_d.rdata = rd_word(s_q, reg_addr);
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset only; the pin reaches state through the flops
  // counter starts clear here, so no spurious pulse in this model
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_q <= RST_S;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------
  // No logic between state and pins, so outputs cannot glitch
  assign core_reset_n    = s_q.sys_rst_n;
  assign irq_req         = s_q.pend;
  assign irq_vector      = s_q.vec;
  assign reg_rdata       = s_q.rdata;
  assign high_osc_enable = s_q.sysctl[`RIC_SC_HI_EN];
  assign low_osc_enable  = s_q.sysctl[`RIC_SC_LO_EN];
  assign main_clk_sel    = s_q.sysctl[`RIC_SC_CLK_SEL];
  assign wdog_enable     = s_q.wdctl[`RIC_WD_WDOG_EN];

endmodule

// [ric_defines.svh]
`ifndef RIC_DEFINES_SVH
`define RIC_DEFINES_SVH

// ----------------------------------------
// Register word offsets on the plain port
// ----------------------------------------
`define RIC_OFS_ENABLE   4'h0
`define RIC_OFS_LATCH    4'h1
`define RIC_OFS_WDCTL    4'h2
`define RIC_OFS_SYSCTL   4'h3
`define RIC_OFS_SELECT   4'h4
`define RIC_OFS_CAUSE    4'h5
`define RIC_OFS_VECTOR   4'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RIC_EN_IMF       0
`define RIC_WD_TRAP_ACT  0
`define RIC_WD_WDOG_ACT  1
`define RIC_WD_RAM_AREA  2
`define RIC_WD_WDOG_EN   3
`define RIC_SC_HI_EN     0
`define RIC_SC_LO_EN     1
`define RIC_SC_CLK_SEL   2
`define RIC_SEL_L11      0
`define RIC_SEL_EXT0     1

// ----------------------------------------
// Vectors, source indices, timing
// ----------------------------------------
`define RIC_VEC_TOP      16'hfffe
`define RIC_SRC_BOOT     4'h0
`define RIC_SRC_SWI      4'h1
`define RIC_MCLK_HZ      25000000
`define RIC_FC_HZ        25000000
`define RIC_MALF_PERIODS 24
`define RIC_MALF_CYCLES  (`RIC_MALF_PERIODS * `RIC_MCLK_HZ / `RIC_FC_HZ)

`endif

// [ric_pkg.sv]
package ric_pkg;

  // ----------------------------------------
  // Reset and boot sequencing
  // ----------------------------------------
  typedef enum logic [2:0] {
    RIC_PH_RESET = 3'b001,
    RIC_PH_BOOT  = 3'b010,
    RIC_PH_RUN   = 3'b100
  } ric_phase_t;

  // ----------------------------------------
  // Whole state of the controller
  // ----------------------------------------
  typedef struct packed {
    logic        pin_s1;
    logic        pin_s2;
    logic [4:0]  malf_cnt;
    logic        sys_rst_n;
    ric_phase_t  phase;
    logic        master_irq_enable;
    logic [15:4] ef;
    logic [15:2] il;
    logic [15:0] imf_stk;
    logic [3:0]  wdctl;
    logic [2:0]  sysctl;
    logic [1:0]  sel;
    logic        swi_pend;
    logic        pend;
    logic [3:0]  src;
    logic [15:0] vec;
    logic [3:0]  cause;
    logic [15:0] rdata;
  } ric_state_t;

endpackage

// [ric_core_model.sv]
`timescale 1ns/1ps
module ric_core_model (
  input  wire logic        mclk,         // Main clock
  input  wire logic        core_reset_n, // Internal reset
  input  wire logic        irq_req,      // Vector waiting
  input  wire logic [15:0] irq_vector,   // Vector address
  input  wire logic [3:0]  ack_delay,    // Idle cycles before taking
  output logic             irq_ack,      // Took the vector
  output logic      [15:0] taken_vec,    // Last vector taken
  output logic      [7:0]  taken_cnt     // Vectors taken so far
);
  logic [3:0] wait_q = 4'h0;
  logic [7:0] cnt_q  = 8'h00;

  // Count survives internal resets so the bench can spot each fetch
  assign taken_cnt = cnt_q;

  // vector fetch: a slow core lets the request stand a while
  always @(posedge mclk) begin
    if (!core_reset_n) begin
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0; // Single pulse, seen at one edge
    end else if (irq_req && wait_q >= ack_delay) begin
      irq_ack <= 1'b1;
      taken_vec <= irq_vector;
      cnt_q <= cnt_q + 8'h01;
      wait_q <= 4'h0;
    end else if (irq_req) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// [ric_top_properties.sv]
`timescale 1ns/1ps
module ric_top_properties (
  input wire logic        mclk,            // Main clock
  input wire logic        reset_n,         // Power reset
  input wire logic        ext_reset_pin_n, // Reset pin
  input wire logic [3:0]  reg_addr,        // Register index
  input wire logic [15:0] reg_wdata,       // Write data
  input wire logic        reg_wr,          // Write strobe
  input wire logic        irq_ack,         // Core took vector
  input wire logic        core_reset_n,    // Internal reset
  input wire logic        irq_req,         // Vector waiting
  input wire logic [15:0] irq_vector,      // Vector address
  input wire logic        high_osc_enable, // High oscillator
  input wire logic        low_osc_enable,  // Low oscillator
  input wire logic        main_clk_sel,    // Clock select
  input wire logic        wdog_enable      // Watchdog enable
);
  logic [5:0] low_cnt_q;

  // Internal reset cycles the pin cannot explain
  always_ff @(posedge mclk) begin
    if (!reset_n || !ext_reset_pin_n || core_reset_n) begin
      low_cnt_q <= 6'h00;
    end else begin
      low_cnt_q <= low_cnt_q + 6'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_bad_clk_wr;
    reg_wr && core_reset_n && reg_addr == 4'h3 && (reg_wdata[1:0] == 2'b00 ||
      (!main_clk_sel && !reg_wdata[0]) || (main_clk_sel && !reg_wdata[1]));
  endsequence
  sequence s_malf_hold;
    ##[1:2] (!core_reset_n) [*8];
  endsequence

  property p_clk_reset;
    s_bad_clk_wr |-> s_malf_hold;
  endproperty
  property p_osc_keep;
    s_bad_clk_wr |=> $stable(high_osc_enable) && $stable(low_osc_enable);
  endproperty
  property p_malf_max;
    low_cnt_q <= 6'h18;
  endproperty
  property p_boot_vec;
    $rose(core_reset_n) |=> irq_req && irq_vector == 16'hfffe;
  endproperty
  property p_vec_hold;
    irq_req && !irq_ack |=> !core_reset_n || (irq_req && $stable(irq_vector));
  endproperty
  property p_ack_drop;
    irq_req && irq_ack |=> !irq_req;
  endproperty
  property p_pin_reset;
    $fell(ext_reset_pin_n) |-> ##[1:4] !core_reset_n;
  endproperty
  property p_wdog_on;
    $rose(core_reset_n) |-> wdog_enable;
  endproperty

  a_clk_reset: assert property (p_clk_reset) else $error("no reset on clock write");
  a_osc_keep: assert property (p_osc_keep) else $error("oscillator stopped");
  a_malf_max: assert property (p_malf_max) else $error("reset held too long");
  a_boot_vec: assert property (p_boot_vec) else $error("no boot vector");
  a_vec_hold: assert property (p_vec_hold) else $error("vector not held");
  a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed");
  a_wdog_on: assert property (p_wdog_on) else $error("watchdog off after reset");
endmodule

bind ric_top ric_top_properties u_props (
  .mclk(mclk), .reset_n(reset_n), .ext_reset_pin_n(ext_reset_pin_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .irq_ack(irq_ack),
  .core_reset_n(core_reset_n), .irq_req(irq_req), .irq_vector(irq_vector),
  .high_osc_enable(high_osc_enable), .low_osc_enable(low_osc_enable),
  .main_clk_sel(main_clk_sel), .wdog_enable(wdog_enable)
);

// [reset_and_interrupt_control_tb_top.sv]
`timescale 1ns/1ps
module reset_and_interrupt_control_tb_top;
  logic mclk = 1'b0, reset_n = 1'b0, pin_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0, ack_dly = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, fetch_addr = 16'h0000, rdata, irq_vector, tvec;
  logic [16:0] src = 17'h00000; // Bit 2 is the opcode fetch, bit 16 ext pin 3
  logic fetch_valid = 1'b0, reti = 1'b0, irq_ack, core_reset_n, irq_req;
  logic hi_osc, lo_osc, clk_sel, wdog_en;
  logic [7:0] tcnt, last_cnt = 8'h00;
  int bad_count = 0, cmp_count = 0;

  always #20 mclk = ~mclk;

  ric_top dut (.mclk(mclk), .reset_n(reset_n), .ext_reset_pin_n(pin_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .wdog_timeout(src[3]), .software_irq(src[0]), .illegal_opcode_irq(src[1]),
    .ext_pin0_irq(src[4]), .ext_pin1_irq(src[5]), .time_base_irq(src[6]),
    .timer_one_irq(src[7]), .serial_rx_irq(src[8]), .serial_tx_irq(src[9]),
    .timer_three_irq(src[10]), .timer_four_irq(src[11]), .ext_pin3_irq(src[16]),
    .converter_done_irq(src[12]), .sync_serial_irq(src[13]), .ext_pin4_irq(src[14]),
    .ext_pin5_irq(src[15]), .irq_ack(irq_ack), .reti_strobe(reti),
    .core_reset_n(core_reset_n), .irq_req(irq_req), .irq_vector(irq_vector),
    .high_osc_enable(hi_osc), .low_osc_enable(lo_osc), .main_clk_sel(clk_sel),
    .wdog_enable(wdog_en));

  ric_core_model core (.mclk(mclk), .core_reset_n(core_reset_n), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_delay(ack_dly), .irq_ack(irq_ack),
    .taken_vec(tvec), .taken_cnt(tcnt));

  // ----------------------------------------
  // Shared bus and compare tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check("register", rdata, exp);
  endtask
  // Short pulses: sources, fetch, or return from interrupt
  task automatic pulse(input logic [16:0] m, input logic [15:0] a, input logic r);
    @(posedge mclk);
    src <= m;
    fetch_valid <= m[2];
    fetch_addr <= a;
    reti <= r;
    @(posedge mclk);
    src <= 17'h00000;
    fetch_valid <= 1'b0;
    reti <= 1'b0;
  endtask
  // Wait for the core to take a vector; a hang shows as a mismatch
  task automatic take(input logic [15:0] exp);
    for (int i = 0; i < 200 && tcnt == last_cnt; i++) tick(1);
    check("vector", (tcnt != last_cnt) ? tvec : 16'hxxxx, exp);
    last_cnt = tcnt;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot;
    take(16'hfffe);
    check("wdog en", {15'h0, wdog_en}, 16'h0001);
    check("osc", {13'h0, clk_sel, lo_osc, hi_osc}, 16'h0001);
    rdchk(4'h0, 16'h0000);
    rdchk(4'h1, 16'h0000);
    rdchk(4'h2, 16'h000f);
    rdchk(4'hf, 16'h0000); // Unmapped
  endtask
  task automatic t_mask;
    wr(4'h0, 16'h0090);
    pulse(17'h00090, 16'h0000, 1'b0);
    tick(4);
    rdchk(4'h1, 16'h0090);
    wr(4'h1, 16'hff7f);
    rdchk(4'h1, 16'h0010);
    wr(4'h1, 16'hffef);
    wr(4'h1, 16'hffff);
    rdchk(4'h1, 16'h0000);
    check("taken", {8'h00, tcnt}, {8'h00, last_cnt});
  endtask
  task automatic t_levels;
    for (int n = 4; n <= 16; n++) begin
      wr(4'h4, (n == 4) ? 16'h0002 : (n == 16) ? 16'h0001 : 16'h0000);
      wr(4'h0, 16'hfff1);
      pulse(17'h00001 << n, 16'h0000, 1'b0);
      take(16'hfff6 - 16'(2 * (((n == 16) ? 11 : n) - 4)));
      rdchk(4'h1, 16'h0000);
      rdchk(4'h0, 16'hfff0);
      pulse(17'h00000, 16'h0000, 1'b1);
      rdchk(4'h0, 16'hfff1);
    end
  endtask
  task automatic t_prio;
    ack_dly = 4'h5;
    wr(4'h0, 16'h1081);
    pulse(17'h01080, 16'h0000, 1'b0);
    take(16'hfff0);
    rdchk(4'h1, 16'h1000);
    rdchk(4'h6, 16'hfff0);
    pulse(17'h00000, 16'h0000, 1'b1);
    take(16'hffe6);
    pulse(17'h00000, 16'h0000, 1'b1);
    ack_dly = 4'h0;
  endtask
  task automatic t_nmi;
    logic [16:0] m[5] = '{17'h1, 17'h2, 17'h8, 17'h4, 17'h4};
    logic [15:0] a[5] = '{16'h0, 16'h0, 16'h0, 16'h0010, 16'h0040};
    logic [15:0] v[5] = '{16'hfffc, 16'hfffc, 16'hfff8, 16'hfffa, 16'hfffa};
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h000c);
    for (int k = 0; k < 5; k++) begin
      pulse(m[k], a[k], 1'b0);
      take(v[k]);
    end
  endtask
  task automatic t_malf;
    int n;
    for (int k = 0; k < 5; k++) begin
      wr(4'h2, 16'h000f);
      wr(4'h0, 16'hfff1);
      wr(4'h5, 16'h000f);
      if (k == 4) wr(4'h3, 16'h0007);
      if (k < 2) pulse((k == 0) ? 17'h8 : 17'h4, 16'h0010, 1'b0);
      else wr(4'h3, (k == 2) ? 16'h0000 : (k == 3) ? 16'h0002 : 16'h0005);
      #1 check("high osc", {15'h0, hi_osc}, 16'h0001);
      check("low osc", {15'h0, lo_osc}, 16'((k == 4) ? 1 : 0));
      for (int i = 0; i < 8 && core_reset_n; i++) tick(1);
      for (n = 0; n < 60 && !core_reset_n; n++) tick(1);
      check("hold ok", 16'((n >= 1) && (n <= 24)), 16'h0001);
      take(16'hfffe);
      rdchk(4'h0, 16'h0000);
      rdchk(4'h5, (k == 0) ? 16'h0004 : (k == 1) ? 16'h0002 : 16'h0008);
    end
  endtask
  task automatic t_pin;
    @(posedge mclk);
    pin_n <= 1'b0;
    repeat (12) @(posedge mclk);
    pin_n <= 1'b1;
    #1 check("pin reset", {15'h0, core_reset_n}, 16'h0000);
    take(16'hfffe);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    tick(40000);
    bad_count++;
    results();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    t_boot();
    t_mask();
    t_levels();
    t_prio();
    t_nmi();
    t_malf();
    t_pin();
    results();
  end
endmodule
